// File: design/desr_defines.svh
`ifndef DESR_DEFINES_SVH
`define DESR_DEFINES_SVH

// control register selectors used by the move-to/from-control port
`define DESR_SEL_CORE_INDEX 5'h00
`define DESR_SEL_EXC_CLEAR 5'h01
`define DESR_SEL_EXC_FLAG 5'h02
`define DESR_SEL_POLY_A 5'h03
`define DESR_SEL_POLY_B 5'h04
`define DESR_SEL_INT_CAUSE 5'h05
`define DESR_SEL_LOOP_COUNT 5'h06
`define DESR_SEL_IRQ_SAVE 5'h07
`define DESR_SEL_EXC_SAVE 5'h08

// exception flag positions
`define DESR_EFR_NMI 31
`define DESR_EFR_EXT 30
`define DESR_EFR_INT 1
`define DESR_EFR_SOFT 0

// internal cause positions
`define DESR_CAUSE_MISSED_STALL 8
`define DESR_CAUSE_LOOP_BUFFER 7
`define DESR_CAUSE_PRIVILEGE 6
`define DESR_CAUSE_RES_ACCESS 5
`define DESR_CAUSE_RES_CONFLICT 4
`define DESR_CAUSE_BAD_OPCODE 3
`define DESR_CAUSE_EXEC_PACKET 2
`define DESR_CAUSE_FETCH_PACKET 1
`define DESR_CAUSE_INSTR_FETCH 0
`define DESR_CAUSE_MASK 32'h0000_01ff

// task state save layout
`define DESR_SAVE_HWE 16
`define DESR_SAVE_IB 15
`define DESR_SAVE_IN_PIPELINED_LOOP_FLAG 14
`define DESR_SAVE_GIE 0
`define DESR_TASK_MASK 32'h0000_06df
`define DESR_SAVE_MASK 32'h0000_c6df
`define DESR_EFR_MASK 32'hc000_0003

// reset values
`define DESR_RESET_ZERO 32'h0000_0000
`define DESR_CORE_INDEX_DEFAULT 32'h0000_0000

`endif

// File: design/desr_pkg.sv
package desr_pkg;
  typedef logic [4:0] desr_sel_t;
  typedef logic [31:0] desr_word_t;
  typedef enum logic [1:0] {
    DESR_ACC_IDLE = 2'b00,
    DESR_ACC_DONE = 2'b01,
    DESR_ACC_DENIED = 2'b10
  } desr_acc_t;
endpackage

// File: design/desr_loop_counter.sv
`include "desr_defines.svh"

module desr_loop_counter
  import desr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // load from a control write
  input wire logic load,
  input wire desr_pkg::desr_word_t load_value,
  // pipelined loop stage boundary
  input wire logic stage_boundary,
  // state
  output desr_pkg::desr_word_t count,
  output logic at_zero
);

  // a load beats a decrement so a restore during the loop is not lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= `DESR_RESET_ZERO;
    end else if (load) begin
      count <= load_value;
    end else if (stage_boundary && (count != 32'h0000_0000)) begin
      count <= count - 32'h0000_0001; // RL13
    end
  end

  assign at_zero = (count == 32'h0000_0000);

endmodule

// File: design/desr_regs.sv
// Behaviour
// RL1: core index is read-only, integration-set at reset; code resets it to DESR_CORE_INDEX_DEFAULT, loads CORE_INDEX a clock later
// RL2: ones written to clear register clear flags
// RL3: writes to flag register never change flags
// RL4: flag, clear, cause, save registers supervisor only
// RL5: nmi flag bit 31, external flag bit 30
// RL6: internal flag bit 1, software flag bit 0
// RL7: first multiplier uses A-side polynomial
// RL8: second multiplier uses B-side polynomial
// RL9: cause register accumulates coinciding internal causes
// RL10: cause bits 8,7,6: stall, loop buffer, privilege
// RL11: cause bits 5,4,3: access, conflict, opcode
// RL12: cause bits 2,1,0: exec packet, fetch packet, fetch
// RL13: loop counter decrements per stage to zero
// RL14: interrupt entry copies task state to save register
// RL15: saved enable bit shared with previous enable bit
// RL16: interrupt save bit 15 blocked, bit 14 loop
// RL17: interrupt save keeps privilege and context fields
// RL18: nmi or exception saves task state and conditions
// RL19: save bit 16 set hardware, cleared software exception
// RL20: exception save bit 15 blocked, bit 14 loop
// RL21: exception save low bits hold task state
// RL22: user access to supervisor register raises privilege
`include "desr_defines.svh"

module desr_regs
  import desr_pkg::*;
#(
  parameter logic [31:0] CORE_INDEX = `DESR_CORE_INDEX_DEFAULT
)(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // move-to/from-control port
  input wire logic ctl_rd,
  input wire logic ctl_wr,
  input wire desr_pkg::desr_sel_t ctl_sel,
  input wire desr_pkg::desr_word_t ctl_wdata,
  output desr_pkg::desr_word_t ctl_rdata,
  output logic ctl_ack,
  output logic ctl_denied,
  // processor mode
  input wire logic supervisor_mode,
  // task state inputs
  input wire desr_pkg::desr_word_t task_state,
  input wire logic irq_blocked_flag,
  input wire logic in_pipelined_loop_flag,
  // events
  input wire logic nmi_taken,
  input wire logic ext_exception_input,
  input wire logic [8:0] internal_cause_in,
  input wire logic soft_exc_instr,
  input wire logic soft_exc_noreturn_instr,
  input wire logic irq_taken,
  // control status shared bit
  input wire logic prev_gie_wr,
  input wire logic prev_gie_wdata,
  output logic prev_global_irq_enable,
  // multiplier polynomial
  input wire logic galois_multiply_instr,
  input wire logic galois_multiply_instr_on_second_unit,
  output desr_pkg::desr_word_t galois_multiply_instr_poly,
  output desr_pkg::desr_word_t poly_a_side_reg,
  output desr_pkg::desr_word_t poly_b_side_reg,
  // pipelined loop counter
  input wire logic stage_boundary,
  output desr_pkg::desr_word_t loop_iter_count_reg,
  output logic loop_count_zero,
  // status
  output desr_pkg::desr_word_t exc_flag_reg,
  output desr_pkg::desr_word_t internal_cause_reg,
  output desr_pkg::desr_word_t irq_state_save_reg,
  output desr_pkg::desr_word_t exc_state_save_reg,
  output desr_pkg::desr_word_t core_index_reg,
  output logic exception_pending
);

  import desr_pkg::*;

  desr_acc_t acc_state;
  logic any_acc;
  logic priv_sel;
  logic priv_fault;
  logic wr_ok;
  logic soft_exc;
  logic hw_exc;
  logic int_exc;
  logic [8:0] cause_now;
  desr_word_t next_rdata;
  desr_word_t clear_bits;
  desr_word_t set_bits;
  desr_word_t irq_cap;
  desr_word_t irq_wr;

  function automatic logic is_supervisor_only(input desr_sel_t sel);
    case (sel)
      `DESR_SEL_EXC_CLEAR,
      `DESR_SEL_EXC_FLAG,
      `DESR_SEL_INT_CAUSE,
      `DESR_SEL_IRQ_SAVE,
      `DESR_SEL_EXC_SAVE: is_supervisor_only = 1'b1;
      default: is_supervisor_only = 1'b0;
    endcase
  endfunction

  function automatic desr_word_t capture_task(input desr_word_t ts, input logic blk,
                                              input logic lp);
    desr_word_t v;
    v = ts & `DESR_TASK_MASK;
    v[`DESR_SAVE_IB] = blk;
    v[`DESR_SAVE_IN_PIPELINED_LOOP_FLAG] = lp;
    capture_task = v;
  endfunction

  assign any_acc = ctl_rd | ctl_wr;
  assign priv_sel = is_supervisor_only(ctl_sel);
  assign priv_fault = any_acc && priv_sel && !supervisor_mode; // RL4 RL22
  assign wr_ok = ctl_wr && !priv_fault;
  assign soft_exc = soft_exc_instr | soft_exc_noreturn_instr;

  // the denied access is folded into the cause so it shows like any other source
  always_comb begin
    cause_now = internal_cause_in;
    cause_now[`DESR_CAUSE_PRIVILEGE] = internal_cause_in[`DESR_CAUSE_PRIVILEGE] | priv_fault; // RL22
  end

  assign int_exc = |cause_now;
  assign hw_exc = nmi_taken | ext_exception_input | int_exc;

  // core identity
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_index_reg <= `DESR_CORE_INDEX_DEFAULT;
    end else begin
      core_index_reg <= CORE_INDEX; // RL1
    end
  end

  // exception flags: direct writes ignored, set wins over clear
  always_comb begin
    set_bits = `DESR_RESET_ZERO;
    set_bits[`DESR_EFR_NMI] = nmi_taken; // RL5
    set_bits[`DESR_EFR_EXT] = ext_exception_input; // RL5
    set_bits[`DESR_EFR_INT] = int_exc; // RL6
    set_bits[`DESR_EFR_SOFT] = soft_exc; // RL6
    clear_bits = `DESR_RESET_ZERO;
    if (wr_ok && ctl_sel == `DESR_SEL_EXC_CLEAR) begin
      clear_bits = ctl_wdata & `DESR_EFR_MASK; // RL2
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exc_flag_reg <= `DESR_RESET_ZERO;
    end else begin
      exc_flag_reg <= (exc_flag_reg & ~clear_bits) | set_bits; // RL2 RL3
    end
  end

  assign exception_pending = |exc_flag_reg;

  // internal cause: sources accumulate, software may rewrite
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      internal_cause_reg <= `DESR_RESET_ZERO;
    end else if (wr_ok && ctl_sel == `DESR_SEL_INT_CAUSE) begin
      internal_cause_reg <= (ctl_wdata | {23'h000000, cause_now}) & `DESR_CAUSE_MASK; // RL9
    end else begin
      internal_cause_reg <= internal_cause_reg | {23'h000000, cause_now}; // RL9 RL10 RL11 RL12
    end
  end

  // polynomials
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poly_a_side_reg <= `DESR_RESET_ZERO;
      poly_b_side_reg <= `DESR_RESET_ZERO;
    end else if (wr_ok) begin
      if (ctl_sel == `DESR_SEL_POLY_A) begin
        poly_a_side_reg <= ctl_wdata;
      end
      if (ctl_sel == `DESR_SEL_POLY_B) begin
        poly_b_side_reg <= ctl_wdata;
      end
    end
  end

  // polynomial for the issuing unit, registered with the issue
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      galois_multiply_instr_poly <= `DESR_RESET_ZERO;
    end else if (galois_multiply_instr) begin
      galois_multiply_instr_poly <= galois_multiply_instr_on_second_unit ? poly_b_side_reg : poly_a_side_reg; // RL7 RL8
    end
  end

  desr_loop_counter u_loop (
    .clk(clk),
    .arst_n(arst_n),
    .load(wr_ok && ctl_sel == `DESR_SEL_LOOP_COUNT),
    .load_value(ctl_wdata),
    .stage_boundary(stage_boundary),
    .count(loop_iter_count_reg),
    .at_zero(loop_count_zero)
  );

  // whole words first, so only bit 0 is sliced off below
  assign irq_cap = capture_task(task_state, irq_blocked_flag, in_pipelined_loop_flag);
  assign irq_wr = ctl_wdata & `DESR_SAVE_MASK;

  // interrupt save; bit 0 lives in the shared enable flop below
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_state_save_reg[31:1] <= 31'h0000_0000;
    end else if (irq_taken) begin
      irq_state_save_reg[31:1] <= irq_cap[31:1]; // RL14 RL16 RL17
    end else if (wr_ok && ctl_sel == `DESR_SEL_IRQ_SAVE) begin
      irq_state_save_reg[31:1] <= irq_wr[31:1];
    end
  end

  // one storage bit serves both views
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_global_irq_enable <= 1'b0;
    end else if (irq_taken) begin
      prev_global_irq_enable <= task_state[`DESR_SAVE_GIE]; // RL14 RL15
    end else if (wr_ok && ctl_sel == `DESR_SEL_IRQ_SAVE) begin
      prev_global_irq_enable <= ctl_wdata[`DESR_SAVE_GIE]; // RL15
    end else if (prev_gie_wr) begin
      prev_global_irq_enable <= prev_gie_wdata; // RL15
    end
  end

  assign irq_state_save_reg[0] = prev_global_irq_enable;

  // exception save: hardware sources take precedence over the software instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exc_state_save_reg <= `DESR_RESET_ZERO;
    end else if (hw_exc || soft_exc) begin
      exc_state_save_reg <=
        capture_task(task_state, irq_blocked_flag, in_pipelined_loop_flag); // RL18 RL20 RL21
      exc_state_save_reg[`DESR_SAVE_HWE] <= hw_exc; // RL19
    end else if (wr_ok && ctl_sel == `DESR_SEL_EXC_SAVE) begin
      exc_state_save_reg <= ctl_wdata & (`DESR_SAVE_MASK | 32'h0001_0000);
    end
  end

  // read mux
  always_comb begin
    case (ctl_sel)
      `DESR_SEL_CORE_INDEX: next_rdata = core_index_reg;
      `DESR_SEL_EXC_FLAG: next_rdata = exc_flag_reg;
      `DESR_SEL_POLY_A: next_rdata = poly_a_side_reg;
      `DESR_SEL_POLY_B: next_rdata = poly_b_side_reg;
      `DESR_SEL_INT_CAUSE: next_rdata = internal_cause_reg;
      `DESR_SEL_LOOP_COUNT: next_rdata = loop_iter_count_reg;
      `DESR_SEL_IRQ_SAVE: next_rdata = irq_state_save_reg;
      `DESR_SEL_EXC_SAVE: next_rdata = exc_state_save_reg;
      default: next_rdata = `DESR_RESET_ZERO;
    endcase
  end

  // access outcome, one cycle after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_state <= DESR_ACC_IDLE;
      ctl_rdata <= `DESR_RESET_ZERO;
    end else begin
      case ({any_acc, priv_fault})
        2'b10: acc_state <= DESR_ACC_DONE;
        2'b11: acc_state <= DESR_ACC_DENIED; // RL22
        default: acc_state <= DESR_ACC_IDLE;
      endcase
      // a denied read returns zero so no supervisor state leaks
      if (ctl_rd && !priv_fault) begin
        ctl_rdata <= next_rdata; // RL4
      end else if (any_acc) begin
        ctl_rdata <= `DESR_RESET_ZERO;
      end
    end
  end

  assign ctl_ack = (acc_state == DESR_ACC_DONE);
  assign ctl_denied = (acc_state == DESR_ACC_DENIED);

endmodule

// File: testbench/desr_regs_assertions.sv
module desr_regs_chk
  import desr_pkg::*;
(
  // clock, reset, control port
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctl_rd,
  input wire logic ctl_wr,
  input wire desr_pkg::desr_sel_t ctl_sel,
  input wire desr_pkg::desr_word_t ctl_wdata,
  input wire logic ctl_denied,
  input wire logic supervisor_mode,
  // events
  input wire desr_pkg::desr_word_t task_state,
  input wire logic irq_blocked_flag,
  input wire logic in_pipelined_loop_flag,
  input wire logic nmi_taken,
  input wire logic ext_exception_input,
  input wire logic [8:0] internal_cause_in,
  input wire logic soft_exc_instr,
  input wire logic irq_taken,
  input wire logic galois_multiply_instr,
  input wire logic galois_multiply_instr_on_second_unit,
  input wire logic stage_boundary,
  // registers
  input wire logic prev_global_irq_enable,
  input wire desr_pkg::desr_word_t galois_multiply_instr_poly,
  input wire desr_pkg::desr_word_t poly_a_side_reg,
  input wire desr_pkg::desr_word_t poly_b_side_reg,
  input wire desr_pkg::desr_word_t loop_iter_count_reg,
  input wire desr_pkg::desr_word_t exc_flag_reg,
  input wire desr_pkg::desr_word_t internal_cause_reg,
  input wire desr_pkg::desr_word_t irq_state_save_reg,
  input wire desr_pkg::desr_word_t exc_state_save_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire int_evt = |internal_cause_in;
  wire hw_evt = nmi_taken | ext_exception_input | int_evt;
  wire desr_word_t ts = task_state & 32'h0000_06df;
  sequence s_quiet_wr(s);
    ctl_wr && supervisor_mode && ctl_sel == s && !hw_evt && !soft_exc_instr;
  endsequence
  sequence s_user_req;
    (ctl_rd || ctl_wr) && !supervisor_mode && ctl_sel inside {1, 2, 5, 7, 8};
  endsequence
  sequence s_refused;
    ctl_denied ##[0:1] (internal_cause_reg[6] && exc_flag_reg[1]);
  endsequence
  property p_flag_set;
    ({$past(nmi_taken), $past(ext_exception_input), $past(int_evt), $past(soft_exc_instr)}
      & ~{exc_flag_reg[31:30], exc_flag_reg[1:0]}) == 4'h0;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_flag_hold;
    s_quiet_wr(5'h02) |=> $stable(exc_flag_reg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag write took effect");
  property p_clear;
    s_quiet_wr(5'h01) |=> exc_flag_reg == ($past(exc_flag_reg) & ~$past(ctl_wdata));
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");
  property p_deny;
    s_user_req |=> s_refused;
  endproperty
  a_deny: assert property (p_deny) else $error("user access not refused");
  property p_poly;
    galois_multiply_instr && !ctl_wr |=> galois_multiply_instr_poly ==
      ($past(galois_multiply_instr_on_second_unit) ? $past(poly_b_side_reg) : $past(poly_a_side_reg));
  endproperty
  a_poly: assert property (p_poly) else $error("wrong polynomial");
  property p_loop;
    stage_boundary && !ctl_wr |=> loop_iter_count_reg ==
      (($past(loop_iter_count_reg) == 0) ? 32'h0 : $past(loop_iter_count_reg) - 32'h1);
  endproperty
  a_loop: assert property (p_loop) else $error("loop count step wrong");
  property p_irq_save;
    irq_taken |=> irq_state_save_reg == ({16'h0, $past(irq_blocked_flag),
      $past(in_pipelined_loop_flag), 14'h0} | $past(ts));
  endproperty
  a_irq_save: assert property (p_irq_save) else $error("irq save wrong");
  property p_shared;
    irq_state_save_reg[0] == prev_global_irq_enable;
  endproperty
  a_shared: assert property (p_shared) else $error("enable bits differ");
  property p_exc_save;
    nmi_taken || ext_exception_input |=> exc_state_save_reg == ({15'h0, 1'b1,
      $past(irq_blocked_flag), $past(in_pipelined_loop_flag), 14'h0} | $past(ts));
  endproperty
  a_exc_save: assert property (p_exc_save) else $error("exc save wrong");
  property p_soft_hwe;
    soft_exc_instr && !hw_evt |=> !exc_state_save_reg[16];
  endproperty
  a_soft_hwe: assert property (p_soft_hwe) else $error("hw bit not cleared");
endmodule

bind desr_regs desr_regs_chk desr_regs_chk_inst (.*);

// File: testbench/tb.sv
module tb;
  import desr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam desr_word_t CORE_ID = 32'h0000_0005; // arbitrary value
  logic clk = 1'b0, arst_n = 1'b0, ctl_rd = 1'b0, ctl_wr = 1'b0, supervisor_mode = 1'b1;
  logic nmi_taken = 1'b0, ext_exception_input = 1'b0, soft_exc_instr = 1'b0;
  logic soft_exc_noreturn_instr = 1'b0, irq_taken = 1'b0, prev_gie_wr = 1'b0;
  logic prev_gie_wdata = 1'b0, galois_multiply_instr = 1'b0, galois_multiply_instr_on_second_unit = 1'b0;
  logic stage_boundary = 1'b0, irq_blocked_flag = 1'b0, in_pipelined_loop_flag = 1'b0;
  logic [8:0] internal_cause_in = 9'h000;
  desr_sel_t ctl_sel = 5'h00;
  desr_word_t ctl_wdata = 32'h0, task_state = 32'h0;
  desr_word_t ctl_rdata, galois_multiply_instr_poly, poly_a_side_reg, poly_b_side_reg, loop_iter_count_reg;
  desr_word_t exc_flag_reg, internal_cause_reg, irq_state_save_reg, exc_state_save_reg;
  desr_word_t core_index_reg, v, flags, seed = 32'h0001_7d88;
  logic ctl_ack, ctl_denied, prev_global_irq_enable, loop_count_zero, exception_pending;
  logic [32:0] notes[$];
  logic [32:0] nt;
  desr_sel_t usr_sel[5] = '{5'h01, 5'h02, 5'h05, 5'h07, 5'h08};
  int n_fail = 0, checked = 0;

  desr_regs #(.CORE_INDEX(CORE_ID)) desr_regs_inst (.*);

  always #50 clk = ~clk;

  function automatic desr_word_t lfsr(desr_word_t x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(string nm, desr_word_t e, desr_word_t g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // every access leaves a note; the watcher below settles it when the answer shows
  task automatic acc(bit r, bit w, desr_sel_t s, desr_word_t d, bit dn, desr_word_t e);
    @(negedge clk);
    ctl_rd = r;
    ctl_wr = w;
    ctl_sel = s;
    ctl_wdata = d;
    notes.push_back({dn, e});
    @(negedge clk);
    ctl_rd = 1'b0;
    ctl_wr = 1'b0;
    for (int i = 0; i < 4 && notes.size() > 0; i++) @(negedge clk);
    if (notes.size() > 0) begin
      chk("answer timeout", 32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic wr(desr_sel_t s, desr_word_t d);
    acc(1'b0, 1'b1, s, d, 1'b0, 32'h0);
  endtask

  task automatic rd(desr_sel_t s, desr_word_t e);
    acc(1'b1, 1'b0, s, 32'h0, 1'b0, e);
  endtask

  task automatic pulse(ref logic p);
    @(negedge clk);
    p = 1'b1;
    @(negedge clk);
    p = 1'b0;
  endtask

  always @(posedge clk) begin
    if (arst_n && (ctl_ack === 1'b1 || ctl_denied === 1'b1) && notes.size() == 0) begin
      chk("unexpected answer", 32'h0, 32'h1);
    end else if (arst_n && (ctl_ack === 1'b1 || ctl_denied === 1'b1)) begin
      nt = notes.pop_front();
      chk("ack denied", {30'h0, ~nt[32], nt[32]}, {30'h0, ctl_ack, ctl_denied});
      chk("read data", nt[31:0], ctl_rdata);
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    wr(5'h00, 32'hffff_ffff);
    rd(5'h00, CORE_ID);
    chk("core index", CORE_ID, core_index_reg);
    pulse(nmi_taken);
    pulse(ext_exception_input);
    pulse(soft_exc_instr);
    rd(5'h02, 32'hc000_0001);
    chk("pending set", 32'h1, {31'h0, exception_pending});
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      internal_cause_in = 9'h001 << i;
      @(negedge clk);
      internal_cause_in = 9'h000;
      rd(5'h05, 32'h0000_01ff >> (8 - i));
    end
    wr(5'h02, 32'h0);
    wr(5'h02, 32'hffff_ffff);
    flags = 32'hc000_0003;
    rd(5'h02, flags);
    repeat (3) begin
      seed = lfsr(seed);
      wr(5'h01, seed);
      flags = flags & ~seed;
      rd(5'h02, flags);
    end
    wr(5'h01, 32'hffff_ffff);
    chk("pending clear", 32'h0, {31'h0, exception_pending});
    wr(5'h05, 32'h0);
    supervisor_mode = 1'b0;
    foreach (usr_sel[k]) acc(1'b1, 1'b1, usr_sel[k], 32'hffff_ffff, 1'b1, 32'h0);
    supervisor_mode = 1'b1;
    rd(5'h02, 32'h0000_0002);
    rd(5'h05, 32'h0000_0040);
    seed = lfsr(seed);
    v = seed;
    wr(5'h03, v);
    seed = lfsr(seed);
    wr(5'h04, seed);
    pulse(galois_multiply_instr);
    chk("poly a", v, galois_multiply_instr_poly);
    galois_multiply_instr_on_second_unit = 1'b1;
    pulse(galois_multiply_instr);
    chk("poly b", seed, galois_multiply_instr_poly);
    wr(5'h06, 32'h0000_0003);
    for (int i = 3; i >= 0; i--) begin
      pulse(stage_boundary);
      chk("loop count", 32'(i > 0 ? i - 1 : 0), loop_iter_count_reg);
      chk("loop zero", 32'(i <= 1), {31'h0, loop_count_zero});
    end
    task_state = lfsr(seed);
    irq_blocked_flag = 1'b1;
    in_pipelined_loop_flag = 1'b1;
    pulse(irq_taken);
    v = 32'h0000_c000 | (task_state & 32'h0000_06df);
    rd(5'h07, v);
    prev_gie_wdata = ~v[0];
    pulse(prev_gie_wr);
    rd(5'h07, v ^ 32'h1);
    irq_blocked_flag = 1'b0;
    pulse(nmi_taken);
    v = task_state & 32'h0000_06df;
    rd(5'h08, 32'h0001_4000 | v);
    pulse(soft_exc_instr);
    rd(5'h08, 32'h0000_4000 | v);
    end_of_test();
  end
endmodule
